// [src/dcudc_pkg.sv]
// Purpose: Shared constants, state types and count helpers for the dual clock up/down counter.
// Assumes: A four-bit count; every counter pin is sampled on CLK through a two-stage synchroniser.
// Notes: The synchroniser bus packs the five pin groups at the positions named below.
package dcudc_pkg;

  localparam int COUNT_W = 4;
  localparam logic [COUNT_W-1:0] DECADE_MAX = 4'h9;
  localparam logic [COUNT_W-1:0] BINARY_MAX = 4'hf;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 4'h1;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;

  // Layout of the synchronised pin bus.
  localparam int SYNC_W = 8;
  localparam int POS_UP = 0;
  localparam int POS_DN = 1;
  localparam int POS_LOAD_N = 2;
  localparam int POS_CLEAR = 3;
  localparam int POS_DATA = 4;
  // Idle pins: both count clocks high, load released, clear released, data zero.
  localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h07;

  // Edges from a pin change to the count and terminal outputs following it.
  localparam int PIN_TO_OUT_EDGES = 3;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } dcudc_sync_t;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic up_prev;
    logic dn_prev;
    logic carry_n;
    logic borrow_n;
  } dcudc_state_t;

  localparam dcudc_state_t STATE_RESET = '{count: COUNT_RESET, up_prev: 1'b1, dn_prev: 1'b1,
                                           carry_n: 1'b1, borrow_n: 1'b1};

  // Decade parts decode bits 0 and 3 only; binary parts need all four bits high.
  function automatic logic dcudc_is_max(input logic [COUNT_W-1:0] count, input logic decade);
    if (decade) begin
      return count[0] & count[3];
    end
    return &count;
  endfunction : dcudc_is_max

  function automatic logic [COUNT_W-1:0] dcudc_step_up(input logic [COUNT_W-1:0] count,
                                                       input logic decade);
    if (dcudc_is_max(count, decade)) begin
      return COUNT_ZERO;
    end
    return count + COUNT_ONE;
  endfunction : dcudc_step_up

  function automatic logic [COUNT_W-1:0] dcudc_step_down(input logic [COUNT_W-1:0] count,
                                                         input logic decade);
    if (count == COUNT_ZERO) begin
      return decade ? DECADE_MAX : BINARY_MAX;
    end
    return count - COUNT_ONE;
  endfunction : dcudc_step_down

endpackage : dcudc_pkg

// [src/dcudc_pin_if.sv]
// Purpose: Carries the synchronised counter pins from the synchroniser to the counter core.
// Assumes: All members are already in the CLK domain.
// Notes: The synchroniser drives, the core only reads.
`timescale 1ns/100ps
interface dcudc_pin_if;
  logic up_clk;
  logic dn_clk;
  logic load_n;
  logic clear;
  logic [3:0] data;

  modport sync_side (output up_clk, output dn_clk, output load_n, output clear, output data);
  modport core_side (input up_clk, input dn_clk, input load_n, input clear, input data);
endinterface : dcudc_pin_if

// [src/dcudc_sync.sv]
// Purpose: Two-stage synchroniser for every counter pin.
// Assumes: Pins are asynchronous to CLK; RST_N is synchronous and active low.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module dcudc_sync
  import dcudc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SYNC_W-1:0] raw_pins,
  dcudc_pin_if.sync_side pins
);

  dcudc_sync_t sync_reg;
  dcudc_sync_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = raw_pins;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_reg <= '{meta: SYNC_RESET, stable: SYNC_RESET};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign pins.up_clk = sync_reg.stable[POS_UP];
  assign pins.dn_clk = sync_reg.stable[POS_DN];
  assign pins.load_n = sync_reg.stable[POS_LOAD_N];
  assign pins.clear = sync_reg.stable[POS_CLEAR];
  assign pins.data = sync_reg.stable[POS_DATA +: COUNT_W];

endmodule : dcudc_sync

// [src/dcudc_top.sv]
// Purpose: Dual clock synchronous up/down counter, decade or binary, sampled on CLK.
// Assumes: All counter pins are asynchronous and pass the two-stage synchroniser first.
// Notes: Clock pin edges are detected on the sampled levels, so pin pulses must last
//        at least two CLK periods high and two low to be seen.
`timescale 1ns/100ps

// Function
// - Four-bit count, maximum 9 or 15.
// - Up clock rising edge adds one.
// - Down clock rising edge subtracts one.
// - All count bits update together.
// - No LSB toggle while either clock low.
// - Both terminal outputs rest high.
// - Carry low while at maximum, up low.
// - Borrow low while zero, down low.
// - Terminal outputs decoded from bits and clocks.
// - Terminal outputs can clock next stage.
// - Load low copies preset data, ignoring clocks.
// - Clear high forces count to zero.
// - Clear overrides load and both clocks.
// - First rising edge after release counts.
module dcudc_top
  import dcudc_pkg::*;
#(
  parameter bit DECADE = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic UP_COUNT_CLOCK,
  input wire logic DOWN_COUNT_CLOCK,
  input wire logic ASYNC_LOAD_N,
  input wire logic ASYNC_CLEAR,
  input wire logic [COUNT_W-1:0] PRESET_DATA,
  output logic [COUNT_W-1:0] COUNT_Q,
  output logic CARRY_OUT_N,
  output logic BORROW_OUT_N
);

  // width and maximum
  // Four bits throughout; DECADE picks 9 or 15 as the top of the count.
  dcudc_pin_if pins ();

  dcudc_sync u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .raw_pins({PRESET_DATA, ASYNC_CLEAR, ASYNC_LOAD_N, DOWN_COUNT_CLOCK, UP_COUNT_CLOCK}),
    .pins(pins.sync_side)
  );

  dcudc_state_t st_reg;
  dcudc_state_t st_next;
  logic up_rise;
  logic dn_rise;
  logic ctrl_idle;

  // Edge detection runs even during clear and load, so a clock held low through them
  // still shows its first rising edge afterwards.
  assign up_rise = !st_reg.up_prev && pins.up_clk;
  assign dn_rise = !st_reg.dn_prev && pins.dn_clk;
  assign ctrl_idle = !pins.clear && pins.load_n;

  always_comb begin
    st_next = st_reg;
    st_next.up_prev = pins.up_clk;
    st_next.dn_prev = pins.dn_clk;
    if (pins.clear) begin
      st_next.count = COUNT_ZERO;
    end else if (!pins.load_n) begin
      st_next.count = pins.data;
    end else if (up_rise && pins.dn_clk && !dn_rise) begin
      st_next.count = dcudc_step_up(st_reg.count, DECADE);
    end else if (dn_rise && pins.up_clk && !up_rise) begin
      st_next.count = dcudc_step_down(st_reg.count, DECADE);
    end
    st_next.carry_n = !(dcudc_is_max(st_next.count, DECADE) && !pins.up_clk);
    st_next.borrow_n = !((st_next.count == COUNT_ZERO) && !pins.dn_clk);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign COUNT_Q = st_reg.count;
  assign CARRY_OUT_N = st_reg.carry_n;
  assign BORROW_OUT_N = st_reg.borrow_n;

  default clocking cb @(posedge CLK);
  endclocking

  default disable iff (!RST_N);

  clear_forces_zero_a: assert property (
    pins.clear |=> (COUNT_Q == COUNT_ZERO)
  ) else $error("count not zero after clear");

  clear_beats_load_a: assert property (
    (pins.clear && !pins.load_n) [*2] |=> (COUNT_Q == COUNT_ZERO)
  ) else $error("load overrode clear");

  load_copies_data_a: assert property (
    (!pins.clear && !pins.load_n) |=> (COUNT_Q == $past(pins.data))
  ) else $error("preset data not copied");

  up_step_a: assert property (
    (ctrl_idle && !st_reg.up_prev && pins.up_clk && st_reg.dn_prev && pins.dn_clk)
      |=> (COUNT_Q == dcudc_step_up($past(COUNT_Q), DECADE))
  ) else $error("up edge did not add one");

  down_step_a: assert property (
    (ctrl_idle && !st_reg.dn_prev && pins.dn_clk && st_reg.up_prev && pins.up_clk)
      |=> (COUNT_Q == dcudc_step_down($past(COUNT_Q), DECADE))
  ) else $error("down edge did not subtract one");

  lsb_frozen_a: assert property (
    (ctrl_idle && (!pins.up_clk || !pins.dn_clk)) |=> $stable(COUNT_Q)
  ) else $error("count moved while a clock was low");

  hold_idle_a: assert property (
    (ctrl_idle && !up_rise && !dn_rise) |=> (COUNT_Q == $past(COUNT_Q))
  ) else $error("count changed without an edge");

  count_range_a: assert property (
    (ctrl_idle && $past(ctrl_idle) && $past(pins.load_n, 2) && $past(COUNT_Q) <= (DECADE ? DECADE_MAX : BINARY_MAX))
      |-> (COUNT_Q <= (DECADE ? DECADE_MAX : BINARY_MAX))
  ) else $error("count left its range");

  carry_rest_a: assert property (
    !dcudc_is_max(COUNT_Q, DECADE) |-> CARRY_OUT_N
  ) else $error("carry low away from maximum");

  carry_mirror_a: assert property (
    $rose(pins.up_clk) && dcudc_is_max(st_next.count, DECADE) |=> CARRY_OUT_N ##1 !$past(pins.up_clk) || CARRY_OUT_N
  ) else $error("carry did not return high");

  carry_low_a: assert property (
    (ctrl_idle && !pins.up_clk && !up_rise && dcudc_is_max(COUNT_Q, DECADE)) |=> !CARRY_OUT_N
  ) else $error("carry not low at maximum with up clock low");

  borrow_rest_a: assert property (
    (COUNT_Q != COUNT_ZERO) |-> BORROW_OUT_N
  ) else $error("borrow low away from zero");

  borrow_mirror_a: assert property (
    (ctrl_idle && (COUNT_Q == COUNT_ZERO) && pins.up_clk && !dn_rise) |=> (BORROW_OUT_N == $past(pins.dn_clk))
  ) else $error("borrow does not follow down clock at zero");

endmodule : dcudc_top

// [tb/dcudc_clk_src.sv]
// Purpose: Upstream clock source that drives the up and down count clocks.
// Assumes: Levels change only at falling edges of clk, three cycles after the call.
// Notes: Three cycles per level keeps every pulse above the two-cycle minimum.
`timescale 1ns/100ps
module dcudc_clk_src (
  input wire logic clk,
  output logic up_clk,
  output logic dn_clk
);
  // idle clocks high: the clock not in use rests high.
  initial begin
    up_clk = 1'b1;
    dn_clk = 1'b1;
  end

  // one clock moves: each call changes one selected clock only.
  task automatic drive(input bit dn, input logic v);
    repeat (3) @(negedge clk);
    if (dn) begin
      dn_clk = v;
    end else begin
      up_clk = v;
    end
  endtask : drive
endmodule : dcudc_clk_src

// [tb/tb.sv]
// Purpose: Self-checking bench for the decade build of the dual clock counter, with a binary build checked in the hand tests.
// Assumes: Pins are driven at falling edges; outputs settle three edges later.
// Notes: Table rows cover plain counting, hand tests cover terminals and overrides.
`timescale 1ns/100ps
module tb;
  import dcudc_pkg::*;
  typedef struct {logic [3:0] ld; int up; int dn; logic [3:0] ex;} dcudc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_n = 1'b1;
  logic clear = 1'b0;
  logic [3:0] data = 4'h0;
  logic up_clk, dn_clk, carry_n, borrow_n;
  logic [3:0] q;
  logic [3:0] q_bin;
  logic carry_bin, borrow_bin;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  dcudc_row_t rows [5] = '{'{4'h0, 3, 0, 4'h3}, '{4'h8, 2, 0, 4'h0}, '{4'h0, 0, 1, 4'h9},
                           '{4'h5, 0, 2, 4'h3}, '{4'h9, 1, 1, 4'h9}};

  dcudc_clk_src src (.clk(clk), .up_clk(up_clk), .dn_clk(dn_clk));
  dcudc_top #(.DECADE(1'b1)) dut (.CLK(clk), .RST_N(rst_n), .UP_COUNT_CLOCK(up_clk),
    .DOWN_COUNT_CLOCK(dn_clk), .ASYNC_LOAD_N(load_n), .ASYNC_CLEAR(clear), .PRESET_DATA(data),
    .COUNT_Q(q), .CARRY_OUT_N(carry_n), .BORROW_OUT_N(borrow_n));
  // Binary build on the same pins, so the hand tests also cover the fifteen count.
  dcudc_top #(.DECADE(1'b0)) dut_bin (.CLK(clk), .RST_N(rst_n), .UP_COUNT_CLOCK(up_clk),
    .DOWN_COUNT_CLOCK(dn_clk), .ASYNC_LOAD_N(load_n), .ASYNC_CLEAR(clear), .PRESET_DATA(data),
    .COUNT_Q(q_bin), .CARRY_OUT_N(carry_bin), .BORROW_OUT_N(borrow_bin));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic results;
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // A run far beyond the expected run of under two hundred cycles means a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] ex);
    compares++;
    if (seen !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask : waitn

  task automatic load(input logic [3:0] v);
    data = v;
    load_n = 1'b0;
    waitn(4);
    load_n = 1'b1;
    waitn(3);
  endtask : load

  task automatic pulse(input bit dn, input int n);
    for (int i = 0; i < n; i++) begin
      src.drive(dn, 1'b0);
      src.drive(dn, 1'b1);
    end
  endtask : pulse

  initial begin
    waitn(8);
    rst_n = 1'b1;
    waitn(2);
    chk("count", q, COUNT_ZERO);
    chk("carry", {3'h0, carry_n}, 4'h1);
    chk("borrow", {3'h0, borrow_n}, 4'h1);
    foreach (rows[i]) begin
      load(rows[i].ld);
      chk("load", q, rows[i].ld);
      pulse(1'b0, rows[i].up);
      pulse(1'b1, rows[i].dn);
      waitn(4);
      chk("row", q, rows[i].ex);
    end
    load(DECADE_MAX);
    src.drive(1'b0, 1'b0);
    waitn(4);
    chk("carry", {3'h0, carry_n}, 4'h0);
    chk("bin carry", {3'h0, carry_bin}, 4'h1);
    chk("borrow", {3'h0, borrow_n}, 4'h1);
    src.drive(1'b0, 1'b1);
    waitn(4);
    chk("carry", {3'h0, carry_n}, 4'h1);
    chk("wrap", q, COUNT_ZERO);
    chk("bin up", q_bin, 4'ha);
    src.drive(1'b1, 1'b0);
    waitn(4);
    chk("borrow", {3'h0, borrow_n}, 4'h0);
    src.drive(1'b1, 1'b1);
    waitn(4);
    chk("borrow", {3'h0, borrow_n}, 4'h1);
    chk("wrap", q, DECADE_MAX);
    chk("bin down", q_bin, 4'h9);
    chk("bin borrow", {3'h0, borrow_bin}, 4'h1);
    // Down held low while up pulses: the count must not move.
    src.drive(1'b1, 1'b0);
    pulse(1'b0, 1);
    waitn(4);
    chk("misuse", q, DECADE_MAX);
    data = 4'h5;
    load_n = 1'b0;
    clear = 1'b1;
    waitn(4);
    chk("clear", q, COUNT_ZERO);
    clear = 1'b0;
    load_n = 1'b1;
    waitn(4);
    chk("clear", q, COUNT_ZERO);
    src.drive(1'b1, 1'b1);
    waitn(4);
    chk("first edge", q, DECADE_MAX);
    chk("bin first edge", q_bin, BINARY_MAX);
    results();
  end
endmodule : tb
